//--- design/imt_timer.sv
// Two-channel interval match timer with an AXI4-Lite register slave.
// Assumes all inputs synchronous to clk_in; ce_in low freezes all state.
//
// Implementation choice: the AXI4-Lite interface to the registers.
module imt_timer
   import imt_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        ce_in,
   input  wire logic [7:0]  s_axi_awaddr_in,
   input  wire logic        s_axi_awvalid_in,
   output logic             s_axi_awready_out,
   input  wire logic [31:0] s_axi_wdata_in,
   input  wire logic [3:0]  s_axi_wstrb_in,
   input  wire logic        s_axi_wvalid_in,
   output logic             s_axi_wready_out,
   output logic [1:0]       s_axi_bresp_out,
   output logic             s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   input  wire logic [7:0]  s_axi_araddr_in,
   input  wire logic        s_axi_arvalid_in,
   output logic             s_axi_arready_out,
   output logic [31:0]      s_axi_rdata_out,
   output logic [1:0]       s_axi_rresp_out,
   output logic             s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in,
   output logic [1:0]       match_interrupt_request_out,
   output logic             irq_out
);

   imt_state_t q;
   imt_state_t d;

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   // Merge the two low byte lanes of a write into a 16-bit value
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  st);
      logic [15:0] v;
      v = old;
      if (st[0])
      begin
         v[7:0] = wd[7:0];
      end
      if (st[1])
      begin
         v[15:8] = wd[15:8];
      end
      return v;
   endfunction : merge16

   function automatic logic [5:0] csr_idx(input int ch);
      return ch == 0 ? idx_of(OFF_CSR0) : idx_of(OFF_CSR1);
   endfunction : csr_idx

   function automatic logic [5:0] cnt_idx(input int ch);
      return ch == 0 ? idx_of(OFF_CNT0) : idx_of(OFF_CNT1);
   endfunction : cnt_idx

   function automatic logic [5:0] cor_idx(input int ch);
      return ch == 0 ? idx_of(OFF_COR0) : idx_of(OFF_COR1);
   endfunction : cor_idx

   // Register contents as seen by a read; reserved bits are zero
   function automatic logic [31:0] read_val(input imt_state_t s,
                                            input logic [5:0] ix,
                                            output logic      hit);
      logic [31:0] v;
      v   = 32'h00000000;
      hit = 1'b1;
      if (ix == IDX_RUN)
      begin
         v[1:0] = s.run;
      end
      else if (ix == IDX_IST)
      begin
         v[1:0] = s.ist;
      end
      else if (ix == IDX_IMASK)
      begin
         v[1:0] = s.imask;
      end
      else
      begin
         hit = 1'b0;
         for (int i = 0; i < 2; i++)
         begin
            if (ix == csr_idx(i))
            begin
               v[BIT_FLAG] = s.flag[i];
               v[BIT_IE]   = s.ie[i];
               v[1:0]      = s.cks[i];
               hit         = 1'b1;
            end
            else if (ix == cnt_idx(i))
            begin
               v[15:0] = s.cnt[i];
               hit     = 1'b1;
            end
            else if (ix == cor_idx(i))
            begin
               v[15:0] = s.cor[i];
               hit     = 1'b1;
            end
         end
      end
      return v;
   endfunction : read_val

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb
   begin
      logic             do_wr;
      logic             rd_hit;
      logic             wr_hit;
      logic [31:0]      rv;
      logic [PRE_W-1:0] msk;
      logic             tick;
      logic             match;
      logic             wr_cnt;
      do_wr  = 1'b0;
      rd_hit = 1'b0;
      wr_hit = 1'b0;
      rv     = 32'h00000000;
      msk    = '0;
      tick   = 1'b0;
      match  = 1'b0;
      wr_cnt = 1'b0;
      d      = q;

      // Free-running prescaler shared by both channels
      d.pre = q.pre + 1'b1;

      // Write channel capture, address and data in either order
      if (q.awready && s_axi_awvalid_in)
      begin
         d.aw_held = 1'b1;
         d.awidx   = s_axi_awaddr_in[7:2];
      end
      if (q.wready && s_axi_wvalid_in)
      begin
         d.w_held = 1'b1;
         d.wdata  = s_axi_wdata_in;
         d.wstrb  = s_axi_wstrb_in;
      end
      if (q.bvalid && s_axi_bready_in)
      begin
         d.bvalid = 1'b0;
      end

      do_wr = q.aw_held && q.w_held && !q.bvalid;
      if (do_wr)
      begin
         d.aw_held = 1'b0;
         d.w_held  = 1'b0;
         d.bvalid  = 1'b1;
         wr_hit    = 1'b1;
         if (q.awidx == IDX_RUN)
         begin
            if (q.wstrb[0])
            begin
               d.run = q.wdata[1:0];
            end
         end
         else if (q.awidx == IDX_IST)
         begin
            if (q.wstrb[0])
            begin
               d.ist = q.ist & ~q.wdata[1:0];
            end
         end
         else if (q.awidx == IDX_IMASK)
         begin
            if (q.wstrb[0])
            begin
               d.imask = q.wdata[1:0];
            end
         end
         else
         begin
            wr_hit = 1'b0;
            for (int i = 0; i < 2; i++)
            begin
               if (q.awidx == csr_idx(i))
               begin
                  wr_hit = 1'b1;
                  if (q.wstrb[0])
                  begin
                     d.ie[i]  = q.wdata[BIT_IE];
                     d.cks[i] = q.wdata[1:0];
                     if (q.arm[i] && !q.wdata[BIT_FLAG])
                     begin
                        d.flag[i] = 1'b0;
                     end
                     d.arm[i] = 1'b0;
                  end
               end
               else if (q.awidx == cnt_idx(i))
               begin
                  wr_hit   = 1'b1;
                  d.cnt[i] = merge16(q.cnt[i], q.wdata,
                                     q.wstrb);
               end
               else if (q.awidx == cor_idx(i))
               begin
                  wr_hit   = 1'b1;
                  d.cor[i] = merge16(q.cor[i], q.wdata,
                                     q.wstrb);
               end
            end
         end
         d.bresp = wr_hit ? RESP_OK : RESP_ERR;
      end

      // Read channel: one cycle from address to data
      if (q.rvalid && s_axi_rready_in)
      begin
         d.rvalid = 1'b0;
      end
      if (q.arready && s_axi_arvalid_in)
      begin
         rv       = read_val(q, s_axi_araddr_in[7:2], rd_hit);
         d.rdata  = rv;
         d.rresp  = rd_hit ? RESP_OK : RESP_ERR;
         d.rvalid = 1'b1;
         for (int i = 0; i < 2; i++)
         begin
            if (s_axi_araddr_in[7:2] == csr_idx(i) && q.flag[i])
            begin
               d.arm[i] = 1'b1;
            end
         end
      end

      // Counters; applied after writes so match clear and flag set win
      for (int i = 0; i < 2; i++)
      begin
         msk = PRE_W'((10'h001 << (DIV_LOG0 + 2 * int'(q.cks[i])))
                      - 10'h001);
         tick   = q.run[i] && ((q.pre & msk) == msk);
         match  = tick && (q.cnt[i] == q.cor[i]);
         wr_cnt = do_wr && (q.awidx == cnt_idx(i));
         if (match)
         begin
            d.cnt[i]  = RST_CNT;
            d.flag[i] = 1'b1;
            d.ist[i]  = 1'b1;
         end
         else if (tick && !wr_cnt)
         begin
            d.cnt[i] = q.cnt[i] + 16'h0001;
         end
      end

      // Outputs, registered alongside their sources
      d.mirq    = d.flag & d.ie;
      d.irq     = |(d.ist & d.imask);
      d.awready = !d.aw_held && !d.bvalid;
      d.wready  = !d.w_held && !d.bvalid;
      d.arready = !d.rvalid;
   end

   // -----------------------------------------------------------------
   // State register
   // -----------------------------------------------------------------
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         q         <= '0;
         q.cor     <= {RST_COR, RST_COR};
         q.cnt     <= {RST_CNT, RST_CNT};
         q.awready <= 1'b1;
         q.wready  <= 1'b1;
         q.arready <= 1'b1;
      end
      else if (ce_in)
      begin
         q <= d;
      end
   end

   // -----------------------------------------------------------------
   // Ports
   // -----------------------------------------------------------------
   assign s_axi_awready_out           = q.awready;
   assign s_axi_wready_out            = q.wready;
   assign s_axi_bresp_out             = q.bresp;
   assign s_axi_bvalid_out            = q.bvalid;
   assign s_axi_arready_out           = q.arready;
   assign s_axi_rdata_out             = q.rdata;
   assign s_axi_rresp_out             = q.rresp;
   assign s_axi_rvalid_out            = q.rvalid;
   assign match_interrupt_request_out = q.mirq;
   assign irq_out                     = q.irq;

endmodule : imt_timer

//--- design/imt_pkg.sv
// Constants, register map and state type of the interval match timer.
// Assumes a 20 MHz clock and byte addresses on an AXI4-Lite bus.
// What this block does
// - Two independent channels, each with a 16-bit up-counter, period constant, match flag, enable and clock select.
// - A shared run register holds bit 0 for channel 0 and bit 1 for channel 1; 1 counts, 0 halts.
// - A two-bit select picks the count clock: 00 is clk/8, 01 clk/32, 10 clk/128, 11 clk/512.
// - A counter steps by one on each pulse of its selected clock, only while its run bit is 1.
// - When the counter equals its constant it returns to zero and sets its match flag.
// - A channel requests an interrupt while its match flag and its enable in bit 6 are both 1.
// - The match flag in bit 7 clears only by writing 0 after reading it as 1; writing 1 does nothing.
// - Reserved bits of the run and control registers read 0 and software writes them only with 0.
// - Reset sets each constant to all ones and the run, control and counter registers to zero.
// - Each counter and constant is fully readable and writable; the constant sets the period.
// - The match is taken at the count pulse after equality, so the flag sets at that pulse.
// - A match in the cycle of a counter write clears the counter and the write is lost.
// - A counter write in the cycle of an increment wins; bytes not written keep their value.
package imt_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [31:0] OFF_BASE = 32'hFFFF83D0;
   localparam logic [31:0] OFF_RUN  = 32'hFFFF83D0;
   localparam logic [31:0] OFF_CSR0 = 32'hFFFF83D2;
   localparam logic [31:0] OFF_CNT0 = 32'hFFFF83D4;
   localparam logic [31:0] OFF_COR0 = 32'hFFFF83D6;
   localparam logic [31:0] OFF_CSR1 = 32'hFFFF83D8;
   localparam logic [31:0] OFF_CNT1 = 32'hFFFF83DA;
   localparam logic [31:0] OFF_COR1 = 32'hFFFF83DC;

   // Word index of a register: byte address is four times this
   function automatic logic [5:0] idx_of(input logic [31:0] off);
      logic [31:0] t;
      t = (off - OFF_BASE) >> 1;
      return t[5:0];
   endfunction : idx_of

   localparam logic [5:0] IDX_RUN   = idx_of(OFF_RUN);
   localparam logic [5:0] IDX_IST   = 6'h08;
   localparam logic [5:0] IDX_IMASK = 6'h09;

   // -----------------------------------------------------------------
   // Fields and reset values
   // -----------------------------------------------------------------
   localparam int          BIT_FLAG  = 7;
   localparam int          BIT_IE    = 6;
   localparam int          PRE_W     = 9;
   localparam int          DIV_LOG0  = 3;
   localparam logic [15:0] RST_CNT   = 16'h0000;
   localparam logic [15:0] RST_COR   = 16'hFFFF;
   localparam logic [1:0]  RESP_OK   = 2'h0;
   localparam logic [1:0]  RESP_ERR  = 2'h2;

   typedef struct packed {
      logic [PRE_W-1:0]  pre;
      logic [1:0]        run;
      logic [1:0][1:0]   cks;
      logic [1:0]        ie;
      logic [1:0]        flag;
      logic [1:0]        arm;
      logic [1:0][15:0]  cnt;
      logic [1:0][15:0]  cor;
      logic [1:0]        ist;
      logic [1:0]        imask;
      logic              irq;
      logic [1:0]        mirq;
      logic              awready;
      logic              wready;
      logic              arready;
      logic              aw_held;
      logic [5:0]        awidx;
      logic              w_held;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
   } imt_state_t;

endpackage : imt_pkg

//--- bench/imt_timer_checker.sv
// Concurrent checks on the register bus handshakes of imt_timer.
// Assumes ce_in held high; bound into every imt_timer instance.
module imt_timer_checker
   import imt_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        s_axi_awvalid_in,
   input  wire logic        s_axi_awready_out,
   input  wire logic        s_axi_wvalid_in,
   input  wire logic        s_axi_wready_out,
   input  wire logic [1:0]  s_axi_bresp_out,
   input  wire logic        s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   input  wire logic        s_axi_arvalid_in,
   input  wire logic        s_axi_arready_out,
   input  wire logic [31:0] s_axi_rdata_out,
   input  wire logic [1:0]  s_axi_rresp_out,
   input  wire logic        s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in
);
   // ----------------------------------------------------------------
   // Bus properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   chk_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
      |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
      else $error("write response dropped early");
   chk_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
      |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
      else $error("read data dropped early");
   chk_r_done: assert property (s_axi_rvalid_out && s_axi_rready_in
      |=> !s_axi_rvalid_out) else $error("read data not retired");
   chk_ar_block: assert property (s_axi_rvalid_out
      |-> !s_axi_arready_out) else $error("read taken while busy");
   chk_aw_block: assert property (s_axi_bvalid_out
      |-> !s_axi_awready_out && !s_axi_wready_out)
      else $error("write taken while busy");
   chk_rd_lat: assert property (s_axi_arvalid_in && s_axi_arready_out
      |=> s_axi_rvalid_out) else $error("read answer late");
   chk_wr_lat: assert property (s_axi_awvalid_in && s_axi_awready_out
      && s_axi_wvalid_in && s_axi_wready_out |-> ##2 s_axi_bvalid_out)
      else $error("write answer late");
   chk_rsv_zero: assert property (s_axi_rvalid_out
      |-> s_axi_rdata_out[31:16] == 16'h0000 || s_axi_rresp_out != RESP_OK)
      else $error("upper read bits not zero");
endmodule : imt_timer_checker

bind imt_timer imt_timer_checker chk_i (
   .clk_in(clk_in), .rst_in(rst_in), .s_axi_awvalid_in(s_axi_awvalid_in),
   .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
   .s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out),
   .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
   .s_axi_arvalid_in(s_axi_arvalid_in),
   .s_axi_arready_out(s_axi_arready_out),
   .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
   .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in)
);

//--- bench/imt_axi_host.sv
// Register bus master standing in for the processor side.
// Assumes the slave answers each request; tasks give up after 2000 edges.
module imt_axi_host
(
   input  wire logic        clk_in,
   output logic [7:0]       awaddr_out,
   output logic             awvalid_out,
   input  wire logic        awready_in,
   output logic [31:0]      wdata_out,
   output logic [3:0]       wstrb_out,
   output logic             wvalid_out,
   input  wire logic        wready_in,
   input  wire logic [1:0]  bresp_in,
   input  wire logic        bvalid_in,
   output logic             bready_out,
   output logic [7:0]       araddr_out,
   output logic             arvalid_out,
   input  wire logic        arready_in,
   input  wire logic [31:0] rdata_in,
   input  wire logic [1:0]  rresp_in,
   input  wire logic        rvalid_in,
   output logic             rready_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Edges to wait before raising bready or rready
   int lag;
   initial {awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out} = '0;
   initial {bready_out, araddr_out, arvalid_out, rready_out} = '0;
   // Byte lanes 0 and 1 only; callers write reserved bits as zero
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [1:0] r);
      int   n;
      logic got;
      n = 0;
      got = 1'b0;
      @(posedge clk_in);
      {awaddr_out, awvalid_out, wdata_out, wstrb_out} <= {a, 1'b1, d, s};
      {wvalid_out, bready_out} <= {1'b1, lag == 0};
      while (!got && n < 2000)
      begin
         @(posedge clk_in);
         n++;
         if (awvalid_out && awready_in)
            {awaddr_out, awvalid_out} <= {~a, 1'b0};
         if (wvalid_out && wready_in)
            {wdata_out, wvalid_out} <= {~d, 1'b0};
         if (bvalid_in && bready_out)
            {got, r} = {1'b1, bresp_in};
         else if (n >= lag)
            bready_out <= 1'b1;
      end
      bready_out <= 1'b0;
   endtask : wr
   // A flag is cleared only by a csr read followed by a zero write
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      int   n;
      logic got;
      n = 0;
      got = 1'b0;
      @(posedge clk_in);
      {araddr_out, arvalid_out, rready_out} <= {a, 1'b1, lag == 0};
      while (!got && n < 2000)
      begin
         @(posedge clk_in);
         n++;
         if (arvalid_out && arready_in)
            {araddr_out, arvalid_out} <= {~a, 1'b0};
         if (rvalid_in && rready_out)
            {got, d, r} = {1'b1, rdata_in, rresp_in};
         else if (n >= lag)
            rready_out <= 1'b1;
      end
      rready_out <= 1'b0;
   endtask : rd
endmodule : imt_axi_host

//--- bench/imt_timer_tb.sv
// Self-checking bench for imt_timer driven through imt_axi_host.
// Assumes byte addresses of the hand-over map and a 50 ns clock.
module imt_timer_tb
   import imt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_in, rst_in, awvalid, awready, wvalid, wready, bvalid;
   logic        bready, arvalid, arready, rvalid, rready, irq;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, req, r;
   int          n_mismatch, samples_checked, cyc, t0;
   imt_timer uut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
      .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
      .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
      .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
      .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
      .s_axi_rready_in(rready), .match_interrupt_request_out(req),
      .irq_out(irq));
   imt_axi_host host (.clk_in(clk_in), .awaddr_out(awaddr),
      .awvalid_out(awvalid), .awready_in(awready), .wdata_out(wdata),
      .wstrb_out(wstrb), .wvalid_out(wvalid), .wready_in(wready),
      .bresp_in(bresp), .bvalid_in(bvalid), .bready_out(bready),
      .araddr_out(araddr), .arvalid_out(arvalid), .arready_in(arready),
      .rdata_in(rdata), .rresp_in(rresp), .rvalid_in(rvalid),
      .rready_out(rready));
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   initial
   begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   always @(posedge clk_in) cyc <= cyc + 1;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      host.wr(a, d, s, r);
      chk(32'(r), 32'(RESP_OK));
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
      host.rd(a, v, r);
      chk(v, e);
      chk(32'(r), 32'(er));
   endtask : rd
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : wrap_up
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      for (int i = 0; i < 10; i++)
         rd(8'(4 * i), (i == 3 || i == 6) ? 32'h0000FFFF : 32'h0,
            (i == 7) ? RESP_ERR : RESP_OK);
   endtask : t_reset
   task automatic t_rw;
      host.lag = 3;
      wr(8'h08, 32'h00001234, 4'h3);
      rd(8'h08, 32'h00001234, RESP_OK);
      host.lag = 0;
      host.wr(8'h1C, 32'h0, 4'h1, r);
      chk(32'(r), 32'(RESP_ERR));
      wr(8'h08, 32'h000000AB, 4'h1);
      rd(8'h08, 32'h000012AB, RESP_OK);
      wr(8'h18, 32'h00005A5A, 4'h3);
      rd(8'h18, 32'h00005A5A, RESP_OK);
      wr(8'h10, 32'h00000043, 4'h1);
      rd(8'h10, 32'h00000043, RESP_OK);
   endtask : t_rw
   task automatic t_div;
      for (int s = 0; s < 4; s++)
      begin
         wr(8'h10, 32'(s), 4'h1);
         wr(8'h14, 32'h0, 4'h3);
         t0 = cyc;
         wr(8'h00, 32'h2, 4'h1);
         while (cyc < t0 + (32 << (2 * s))) @(posedge clk_in);
         wr(8'h00, 32'h0, 4'h1);
         rd(8'h14, 32'h4, RESP_OK);
         repeat (100) @(posedge clk_in);
         rd(8'h14, 32'h4, RESP_OK);
      end
      rd(8'h08, 32'h000012AB, RESP_OK);
   endtask : t_div
   task automatic t_match;
      wr(8'h0C, 32'h3, 4'h3);
      wr(8'h08, 32'h0, 4'h3);
      wr(8'h04, 32'h40, 4'h1);
      wr(8'h00, 32'h1, 4'h1);
      for (int i = 0; i < 400 && req[0] !== 1'b1; i++) @(posedge clk_in);
      wr(8'h00, 32'h0, 4'h1);
      chk(32'(req), 32'h1);
      rd(8'h04, 32'hC0, RESP_OK);
      host.rd(8'h08, v, r);
      chk(32'(v < 32'h4), 32'h1);
      rd(8'h10, 32'h3, RESP_OK);
      rd(8'h20, 32'h1, RESP_OK);
      chk(32'(irq), 32'h0);
      wr(8'h24, 32'h1, 4'h1);
      repeat (2) @(posedge clk_in);
      chk(32'(irq), 32'h1);
      wr(8'h20, 32'h1, 4'h1);
      repeat (2) @(posedge clk_in);
      chk(32'(irq), 32'h0);
      rd(8'h20, 32'h0, RESP_OK);
   endtask : t_match
   task automatic t_flag;
      wr(8'h04, 32'h80, 4'h1);
      repeat (2) @(posedge clk_in);
      chk(32'(req[0]), 32'h0);
      wr(8'h04, 32'hC0, 4'h1);
      wr(8'h04, 32'h40, 4'h1);
      repeat (2) @(posedge clk_in);
      chk(32'(req[0]), 32'h1);
      rd(8'h04, 32'hC0, RESP_OK);
      wr(8'h04, 32'h40, 4'h1);
      repeat (2) @(posedge clk_in);
      chk(32'(req[0]), 32'h0);
      rd(8'h04, 32'h40, RESP_OK);
   endtask : t_flag
   initial
   begin
      #(50 * 20000);
      n_mismatch++;
      wrap_up;
   end
   initial
   begin
      rst_in = 1'b1;
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      t_reset;
      t_rw;
      t_div;
      t_match;
      t_flag;
      wrap_up;
   end
endmodule : imt_timer_tb
